// >>> include/decs_regs.svh
// register indices, field positions and reset values of the status bank
`ifndef DECS_REGS_SVH
`define DECS_REGS_SVH
`define DECS_IDX_CLEAR     8'h10
`define DECS_IDX_CORR_HI   8'h1C
`define DECS_IDX_CORR_LO   8'h1D
`define DECS_IDX_UNCORR    8'h1E
`define DECS_IDX_DEV_ID    8'h1F
`define DECS_IDX_REF_DIV   8'h23
`define DECS_IDX_FB_DIV_HI 8'h24
`define DECS_IDX_FB_DIV_LO 8'h25
`define DECS_IDX_LOCK      8'h26
`define DECS_IDX_IRQ_STS   8'h30
`define DECS_IDX_IRQ_MASK  8'h31
`define DECS_BIT_EV_CORR   0
`define DECS_BIT_EV_UNCORR 1
`define DECS_BIT_EV_LOCK   2
`define DECS_EV_W          3
`define DECS_RST_IRQ_MASK  3'h0
`define DECS_RST_COUNT     16'h0000
`define DECS_RST_UNCORR    8'h00
`endif

// >>> include/decs_pkg.sv
// types shared by the decoder error status bank
package decs_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } decs_apb_req_type;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } decs_apb_rsp_type;

    typedef struct packed {
        logic        corrected;
        logic        uncorrected;
    } decs_fec_event_type;
endpackage

// >>> src/decs_top.sv
// decoder error status bank: counters, identifier, test values, apb slave
`timescale 1ns/1ps
`include "decs_regs.svh"

module decs_top #(
    parameter logic [7:0] DEV_ID = 8'h5A,
    parameter int         ADDR_W = 12
) (
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire decs_pkg::decs_apb_req_type   apb_req,
    output      decs_pkg::decs_apb_rsp_type   apb_rsp,
    input  wire decs_pkg::decs_fec_event_type fec_evt,
    input  wire logic [7:0]                   ref_div_test,
    input  wire logic [15:0]                  fb_div_test,
    input  wire logic                         pll_lock,
    output      logic                         irq
);
    import decs_pkg::*;

    // DEV_ID default is an arbitrary neutral value
    // the upper address check needs at least bit 10 present
    if (ADDR_W < 11 || ADDR_W > 12) begin : g_bad_addr_w
        $error("decs_top: ADDR_W must be 11 to 12");
    end

    logic [15:0]          corr_q;
    logic [15:0]          corr_d;
    logic [7:0]           unc_q;
    logic [7:0]           unc_d;
    logic                 lock_s1_q;
    logic                 lock_s2_q;
    logic                 lock_s3_q;
    logic                 lock_q;
    logic [`DECS_EV_W-1:0] sts_q;
    logic [`DECS_EV_W-1:0] sts_d;
    logic [`DECS_EV_W-1:0] mask_q;
    logic [`DECS_EV_W-1:0] ev_set;
    logic [31:0]          rdata_q;
    logic                 slverr_q;

    // bus decode
    wire [7:0] idx     = apb_req.paddr[9:2];
    wire       setup   = apb_req.psel & ~apb_req.penable;
    wire       access  = apb_req.psel & apb_req.penable;
    wire       wr_acc  = access & apb_req.pwrite;
    wire       hit_clr = idx == `DECS_IDX_CLEAR;
    wire       hit_chi = idx == `DECS_IDX_CORR_HI;
    wire       hit_clo = idx == `DECS_IDX_CORR_LO;
    wire       hit_unc = idx == `DECS_IDX_UNCORR;
    wire       hit_id  = idx == `DECS_IDX_DEV_ID;
    wire       hit_ref = idx == `DECS_IDX_REF_DIV;
    wire       hit_fhi = idx == `DECS_IDX_FB_DIV_HI;
    wire       hit_flo = idx == `DECS_IDX_FB_DIV_LO;
    wire       hit_lck = idx == `DECS_IDX_LOCK;
    wire       hit_sts = idx == `DECS_IDX_IRQ_STS;
    wire       hit_msk = idx == `DECS_IDX_IRQ_MASK;
    wire       hit_any = hit_clr | hit_chi | hit_clo | hit_unc | hit_id
                       | hit_ref | hit_fhi | hit_flo | hit_lck | hit_sts
                       | hit_msk;
    wire       addr_ok = hit_any
                       & (apb_req.paddr[ADDR_W-1:10] == '0)
                       & (apb_req.paddr[1:0] == 2'b00);
    wire       clr_wr  = wr_acc & addr_ok & hit_clr;
    wire       sts_wr  = wr_acc & addr_ok & hit_sts;
    wire       msk_wr  = wr_acc & addr_ok & hit_msk;

    // counter next values
    // clear before count
    always_comb begin
        corr_d = clr_wr ? `DECS_RST_COUNT : corr_q;
        unc_d  = clr_wr ? `DECS_RST_UNCORR : unc_q;
        if (fec_evt.corrected) begin
            corr_d = corr_d + 16'h0001;
        end
        if (fec_evt.uncorrected) begin
            unc_d = unc_d + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            corr_q <= `DECS_RST_COUNT;
            unc_q  <= `DECS_RST_UNCORR;
        end else begin
            corr_q <= corr_d;
            unc_q  <= unc_d;
        end
    end

    // lock pin synchroniser; s1 feeds only s2
    // lock status
    always_ff @(posedge clk) begin
        if (reset) begin
            lock_s1_q <= 1'b0;
            lock_s2_q <= 1'b0;
            lock_s3_q <= 1'b0;
            lock_q    <= 1'b0;
        end else begin
            lock_s1_q <= pll_lock;
            lock_s2_q <= lock_s1_q;
            lock_s3_q <= lock_s2_q;
            if (lock_s2_q == lock_s3_q) begin
                lock_q <= lock_s3_q;
            end
        end
    end

    wire lock_chg = (lock_s2_q == lock_s3_q) & (lock_s3_q != lock_q);

    // sticky events, set wins over write-one clear
    assign ev_set[`DECS_BIT_EV_CORR]   = fec_evt.corrected;
    assign ev_set[`DECS_BIT_EV_UNCORR] = fec_evt.uncorrected;
    assign ev_set[`DECS_BIT_EV_LOCK]   = lock_chg;

    always_comb begin
        sts_d = sts_q;
        if (sts_wr) begin
            sts_d = sts_d & ~apb_req.pwdata[`DECS_EV_W-1:0];
        end
        sts_d = sts_d | ev_set;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sts_q  <= '0;
            mask_q <= `DECS_RST_IRQ_MASK;
        end else begin
            sts_q <= sts_d;
            if (msk_wr) begin
                mask_q <= apb_req.pwdata[`DECS_EV_W-1:0];
            end
        end
    end

    assign irq = |(sts_q & mask_q);

    // read mux, captured in the setup cycle
    // byte order
    wire [7:0] rd_byte =
          hit_chi ? corr_q[15:8]
        : hit_clo ? corr_q[7:0]
        : hit_unc ? unc_q
        : hit_id  ? DEV_ID
        : hit_ref ? ref_div_test
        : hit_fhi ? fb_div_test[15:8]
        : hit_flo ? fb_div_test[7:0]
        : hit_lck ? {7'h00, lock_q}
        : hit_sts ? {5'h00, sts_q}
        : hit_msk ? {5'h00, mask_q}
        : 8'h00;

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q  <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (setup) begin
            rdata_q  <= (addr_ok & ~apb_req.pwrite) ? {24'h000000, rd_byte}
                                                    : 32'h0000_0000;
            slverr_q <= ~addr_ok;
        end
    end

    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.prdata  = rdata_q;
    assign apb_rsp.pslverr = access & slverr_q;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    wire rd_setup = setup & ~apb_req.pwrite & addr_ok;

    property p_corr_clear;
        clr_wr & ~fec_evt.corrected |=> corr_q == 16'h0000;
    endproperty
    a_corr_clear: assert property (p_corr_clear)
        else $error("corrected count not cleared");

    property p_corr_count;
        ~clr_wr & fec_evt.corrected |=> corr_q == $past(corr_q) + 16'h0001;
    endproperty
    a_corr_count: assert property (p_corr_count)
        else $error("corrected count did not advance");

    property p_unc_wrap;
        ~clr_wr & fec_evt.uncorrected & (unc_q == 8'hFF) |=> unc_q == 8'h00;
    endproperty
    a_unc_wrap: assert property (p_unc_wrap)
        else $error("uncorrected count did not wrap");

    property p_unc_count;
        ~clr_wr & fec_evt.uncorrected & (unc_q != 8'hFF)
            |=> unc_q == $past(unc_q) + 8'h01;
    endproperty
    a_unc_count: assert property (p_unc_count)
        else $error("uncorrected count did not advance");

    property p_unc_clear;
        clr_wr & ~fec_evt.uncorrected |=> unc_q == 8'h00;
    endproperty
    a_unc_clear: assert property (p_unc_clear)
        else $error("uncorrected count not cleared");

    property p_hold;
        ~clr_wr & ~fec_evt.corrected & ~fec_evt.uncorrected
            |=> $stable(corr_q) && $stable(unc_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counter changed without cause");

    property p_order;
        rd_setup & hit_chi & ~fec_evt.corrected & ~clr_wr
            |=> rdata_q[7:0] == corr_q[15:8];
    endproperty
    a_order: assert property (p_order)
        else $error("high byte of corrected count misplaced");

    property p_dev_id;
        rd_setup & hit_id |=> rdata_q == {24'h000000, DEV_ID};
    endproperty
    a_dev_id: assert property (p_dev_id)
        else $error("identifier read wrong");

    property p_order_lo;
        rd_setup & hit_clo & ~fec_evt.corrected
            |=> rdata_q[7:0] == corr_q[7:0];
    endproperty
    a_order_lo: assert property (p_order_lo)
        else $error("low byte of corrected count misplaced");

    property p_unc_read;
        rd_setup & hit_unc & ~fec_evt.uncorrected
            |=> rdata_q[7:0] == unc_q;
    endproperty
    a_unc_read: assert property (p_unc_read)
        else $error("uncorrected count read wrong");

    property p_ref_div;
        rd_setup & hit_ref
            |=> rdata_q == {24'h000000, $past(ref_div_test)};
    endproperty
    a_ref_div: assert property (p_ref_div)
        else $error("reference divider test value read wrong");

    property p_fb_hi;
        rd_setup & hit_fhi
            |=> rdata_q == {24'h000000, $past(fb_div_test[15:8])};
    endproperty
    a_fb_hi: assert property (p_fb_hi)
        else $error("feedback divider high byte read wrong");

    property p_fb_lo;
        rd_setup & hit_flo
            |=> rdata_q == {24'h000000, $past(fb_div_test[7:0])};
    endproperty
    a_fb_lo: assert property (p_fb_lo)
        else $error("feedback divider low byte read wrong");

    property p_lock_read;
        rd_setup & hit_lck |=> rdata_q == {31'h00000000, $past(lock_q)};
    endproperty
    a_lock_read: assert property (p_lock_read)
        else $error("lock status read wrong");

    sequence s_lock_held;
        pll_lock [*4];
    endsequence
    property p_lock;
        s_lock_held ##1 pll_lock |-> ##[0:2] lock_q;
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock status not reached");

    sequence s_unlock_held;
        ~pll_lock [*4];
    endsequence
    property p_lock_low;
        s_unlock_held ##1 ~pll_lock |-> ##[0:2] ~lock_q;
    endproperty
    a_lock_low: assert property (p_lock_low)
        else $error("lock status not cleared");

    property p_reset_zero;
        @(posedge clk) disable iff (1'b0)
        reset |=> corr_q == 16'h0000 && unc_q == 8'h00;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("counters not zero after reset");
endmodule

// >>> tb/tb_decs_top.sv
// self-checking testbench of the decoder error status bank
`timescale 1ns/1ps
`include "decs_regs.svh"

module tb_decs_top;
    import decs_pkg::*;
    // identifier value is arbitrary
    localparam logic [7:0] DEV_ID = 8'hA7;

    logic               clk;
    logic               reset;
    decs_apb_req_type   apb_req;
    decs_apb_rsp_type   apb_rsp;
    decs_fec_event_type fec_evt;
    logic [7:0]         ref_div_test;
    logic [15:0]        fb_div_test;
    logic               pll_lock;
    logic               irq;
    int                 n_fail;
    int                 num_checks;
    logic [31:0]        rd;
    logic               err;

    decs_top #(.DEV_ID(DEV_ID), .ADDR_W(12)) i_decs_top (
        .clk          (clk),
        .reset        (reset),
        .apb_req      (apb_req),
        .apb_rsp      (apb_rsp),
        .fec_evt      (fec_evt),
        .ref_div_test (ref_div_test),
        .fb_div_test  (fb_div_test),
        .pll_lock     (pll_lock),
        .irq          (irq)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; read data and error taken at the ready edge
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= wr;
        apb_req.paddr   <= a;
        apb_req.pwdata  <= wd;
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        xfer(1'b0, ba(idx), 32'h0);
        chk(rd, exp);
        chk({31'h0, err}, 32'h0);
    endtask

    // n decoder events, one per clock edge
    task automatic pulse(input logic c, input logic u, input int n);
        repeat (n) begin
            @(posedge clk);
            fec_evt.corrected   <= c;
            fec_evt.uncorrected <= u;
        end
        @(posedge clk);
        fec_evt <= '0;
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #500000;
        n_fail++;
        end_of_test;
    end

    initial begin
        n_fail = 0;
        num_checks = 0;
        reset = 1'b1;
        apb_req = '0;
        fec_evt = '0;
        ref_div_test = 8'h3C;
        fb_div_test = 16'hA5C3;
        pll_lock = 1'b0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        rdchk(`DECS_IDX_CORR_HI, 32'h0);
        rdchk(`DECS_IDX_CORR_LO, 32'h0);
        rdchk(`DECS_IDX_UNCORR, 32'h0);
        rdchk(`DECS_IDX_DEV_ID, {24'h0, DEV_ID});
        $display("test reset values done");
        pulse(1'b1, 1'b0, 300);
        rdchk(`DECS_IDX_CORR_HI, 32'h01);
        rdchk(`DECS_IDX_CORR_LO, 32'h2C);
        pulse(1'b0, 1'b1, 257);
        rdchk(`DECS_IDX_UNCORR, 32'h01);
        rdchk(`DECS_IDX_UNCORR, 32'h01);
        rdchk(`DECS_IDX_CORR_HI, 32'h01);
        rdchk(`DECS_IDX_CORR_LO, 32'h2C);
        $display("test counting done");
        xfer(1'b1, ba(`DECS_IDX_CLEAR), 32'h0000005A);
        rdchk(`DECS_IDX_CORR_HI, 32'h0);
        rdchk(`DECS_IDX_CORR_LO, 32'h0);
        rdchk(`DECS_IDX_UNCORR, 32'h0);
        $display("test clear done");
        rdchk(`DECS_IDX_REF_DIV, 32'h3C);
        rdchk(`DECS_IDX_FB_DIV_HI, 32'hA5);
        rdchk(`DECS_IDX_FB_DIV_LO, 32'hC3);
        @(posedge clk);
        pll_lock <= 1'b1;
        repeat (8) @(posedge clk);
        rdchk(`DECS_IDX_LOCK, 32'h01);
        pll_lock <= 1'b0;
        repeat (8) @(posedge clk);
        rdchk(`DECS_IDX_LOCK, 32'h00);
        $display("test test values and lock done");
        xfer(1'b1, ba(`DECS_IDX_IRQ_STS), 32'h7);
        xfer(1'b1, ba(`DECS_IDX_IRQ_MASK), 32'h2);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        pulse(1'b0, 1'b1, 1);
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        pulse(1'b1, 1'b0, 1);
        rdchk(`DECS_IDX_IRQ_STS, 32'h3);
        xfer(1'b1, ba(`DECS_IDX_IRQ_STS), 32'h2);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        rdchk(`DECS_IDX_IRQ_STS, 32'h1);
        rdchk(`DECS_IDX_UNCORR, 32'h01);
        $display("test interrupt done");
        xfer(1'b1, ba(`DECS_IDX_CORR_LO), 32'hFF);
        chk({31'h0, err}, 32'h0);
        rdchk(`DECS_IDX_CORR_LO, 32'h01);
        xfer(1'b0, 12'h800, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        $display("test refused access done");
        end_of_test;
    end
endmodule
